// ===== src/spcs_map.svh
// constants of the serial port control and status block
`ifndef SPCS_MAP_SVH
`define SPCS_MAP_SVH

// control word field positions
`define SPCS_MODE_HI 3
`define SPCS_MODE_LO 2
`define SPCS_EN_BIT 0

// reset values
`define SPCS_MODE_RESET 2'h1
`define SPCS_EN_RESET 1'h0
`define SPCS_MASTER_RESET 1'h0
`define SPCS_TXE_RESET 1'h1
`define SPCS_OVR_RESET 1'h0
`define SPCS_BYTE_RESET 8'h00

// select line mode encodings
`define SPCS_MODE_3WIRE 2'h0
`define SPCS_MODE_4WIRE_IN 2'h1

// counts: serial clock half period in system clock cycles, index of the last bit, receive buffer full level
`define SPCS_SCK_HALF_CYC 4'h4
`define SPCS_LAST_BIT 4'h7
`define SPCS_BUF_FULL 2'h2

`endif

// ===== src/spcs_pkg.sv
// types shared by the serial port control and status block
package spcs_pkg;
    typedef logic [7:0] spcs_byte_t;
    typedef logic [1:0] spcs_mode_t;
    typedef enum logic {SPCS_IDLE, SPCS_RUN} spcs_state_e;
endpackage : spcs_pkg

// ===== src/spcs_shift_if.sv
// link between the control logic and the shift engine
interface spcs_shift_if;
    import spcs_pkg::*;
    logic load;
    spcs_byte_t load_data;
    logic busy;
    logic done;
    spcs_byte_t rx_data;
    modport ctrl (output load, output load_data, input busy, input done, input rx_data);
    modport engine (input load, input load_data, output busy, output done, output rx_data);
endinterface : spcs_shift_if

// ===== src/spcs_rx_buf.sv
// two-entry receive buffer with valid and ready on both sides
`include "spcs_map.svh"
module spcs_rx_buf (
    input wire logic clock,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire spcs_pkg::spcs_byte_t in_data,
    output logic out_valid,
    input wire logic out_ready,
    output spcs_pkg::spcs_byte_t out_data
);
    import spcs_pkg::*;

    spcs_byte_t head_ff, nxt_head;
    spcs_byte_t tail_ff, nxt_tail;
    logic [1:0] cnt_ff, nxt_cnt;
    logic push, pop;

    // head register feeds the output directly, so read data is a flop
    assign in_ready = (cnt_ff != `SPCS_BUF_FULL);
    assign out_valid = (cnt_ff != 2'h0);
    assign out_data = head_ff;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // next slot contents and fill level
    always_comb begin
        nxt_head = head_ff;
        nxt_tail = tail_ff;
        nxt_cnt = cnt_ff;
        case (cnt_ff)
            2'h0: begin
                if (push) begin
                    nxt_head = in_data;
                    nxt_cnt = 2'h1;
                end
            end
            2'h1: begin
                if (push && pop) begin
                    nxt_head = in_data;
                end else if (push) begin
                    nxt_tail = in_data;
                    nxt_cnt = 2'h2;
                end else if (pop) begin
                    nxt_cnt = 2'h0;
                end
            end
            2'h2: begin
                // full: no push is accepted, so only a pop moves things
                if (pop) begin
                    nxt_head = tail_ff;
                    nxt_cnt = 2'h1;
                end
            end
            default: nxt_cnt = 2'h0;
        endcase
    end

    // slot registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            head_ff <= `SPCS_BYTE_RESET;
            tail_ff <= `SPCS_BYTE_RESET;
            cnt_ff <= 2'h0;
        end else begin
            head_ff <= nxt_head;
            tail_ff <= nxt_tail;
            cnt_ff <= nxt_cnt;
        end
    end
endmodule // spcs_rx_buf

// ===== src/spcs_shifter.sv
// byte shift engine, clock idle low, sample on rising edge, shift on falling
`include "spcs_map.svh"
module spcs_shifter (
    input wire logic clock,
    input wire logic rst,
    spcs_shift_if.engine sh,
    input wire logic master,
    input wire logic enable,
    input wire logic active,
    input wire logic sck_in,
    input wire logic data_in,
    output logic sck_out,
    output logic data_out
);
    import spcs_pkg::*;

    spcs_state_e state_ff, nxt_state;
    spcs_byte_t shift_ff, nxt_shift;
    logic [3:0] cnt_ff, nxt_cnt;
    logic [3:0] div_ff, nxt_div;
    logic sck_ff, nxt_sck;
    logic bit_ff, nxt_bit;
    logic prev_ff, nxt_prev;
    logic done_ff, nxt_done;
    logic tick, rise, fall;

    // divider enable pulse sets the serial clock half period
    assign tick = (div_ff == `SPCS_SCK_HALF_CYC - 4'h1);
    assign rise = sck_in && !prev_ff;
    assign fall = !sck_in && prev_ff;
    // a slave counts a fall as busy too, so a load never meets a shift
    assign sh.busy = master ? (state_ff == SPCS_RUN) : ((cnt_ff != 4'h0) || fall);
    assign sh.done = done_ff;
    assign sh.rx_data = shift_ff;
    assign sck_out = sck_ff;
    assign data_out = shift_ff[7];

    // engine next state; the last bit lands on the eighth falling edge
    always_comb begin
        nxt_state = state_ff;
        nxt_shift = shift_ff;
        nxt_cnt = cnt_ff;
        nxt_div = div_ff;
        nxt_sck = sck_ff;
        nxt_bit = bit_ff;
        nxt_prev = sck_in;
        nxt_done = 1'b0;
        if (!enable) begin
            // disabled port drops any partial byte
            nxt_state = SPCS_IDLE;
            nxt_cnt = 4'h0;
            nxt_div = 4'h0;
            nxt_sck = 1'b0;
        end else if (master) begin
            case (state_ff)
                SPCS_IDLE: begin
                    if (sh.load) begin
                        nxt_shift = sh.load_data;
                        nxt_cnt = 4'h0;
                        nxt_div = 4'h0;
                        nxt_state = SPCS_RUN;
                    end
                end
                SPCS_RUN: begin
                    nxt_div = tick ? 4'h0 : div_ff + 4'h1;
                    if (tick && !sck_ff) begin
                        nxt_sck = 1'b1;
                        nxt_bit = data_in;
                    end else if (tick) begin
                        nxt_sck = 1'b0;
                        nxt_shift = {shift_ff[6:0], bit_ff};
                        nxt_cnt = cnt_ff + 4'h1;
                        if (cnt_ff == `SPCS_LAST_BIT) begin
                            nxt_done = 1'b1;
                            nxt_cnt = 4'h0;
                            nxt_state = SPCS_IDLE;
                        end
                    end
                end
                default: nxt_state = SPCS_IDLE;
            endcase
        end else begin
            nxt_state = SPCS_IDLE;
            nxt_sck = 1'b0;
            // the byte is taken even while deselected, since the empty flag rises on the same edge as the load
            if (sh.load) begin
                nxt_shift = sh.load_data;
            end
            if (!active) begin
                nxt_cnt = 4'h0;
            end else if (rise) begin
                nxt_bit = data_in;
            end else if (fall) begin
                nxt_shift = {shift_ff[6:0], bit_ff};
                nxt_cnt = cnt_ff + 4'h1;
                if (cnt_ff == `SPCS_LAST_BIT) begin
                    nxt_done = 1'b1;
                    nxt_cnt = 4'h0;
                end
            end
        end
    end

    // engine registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_ff <= SPCS_IDLE;
            shift_ff <= `SPCS_BYTE_RESET;
            cnt_ff <= 4'h0;
            div_ff <= 4'h0;
            sck_ff <= 1'b0;
            bit_ff <= 1'b0;
            prev_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            shift_ff <= nxt_shift;
            cnt_ff <= nxt_cnt;
            div_ff <= nxt_div;
            sck_ff <= nxt_sck;
            bit_ff <= nxt_bit;
            prev_ff <= nxt_prev;
            done_ff <= nxt_done;
        end
    end
endmodule // spcs_shifter

// ===== src/spcs_top.sv
// serial port control and status bits with shift engine and receive buffer
`include "spcs_map.svh"

// Notes on behaviour
// [R1] overrun set when byte lands, buffer full
// [R2] overrun cleared only by software
// [R3] mode field sits at control bits 3:2
// [R4] mode 00: select line unused, three wire
// [R5] mode 01: select is input; reset default
// [R6] mode 1x: drive select with low bit
// [R7] writing transmit data clears empty flag
// [R8] move into shifter sets empty flag
// [R9] control bit 0 enables the port
// [R10] overrun set also raises interrupt request
module spcs_top (
    input wire logic clock,
    input wire logic rst,
    input wire logic ctrl_wr,
    input wire logic [3:0] ctrl_wdata,
    input wire logic master_select,
    input wire logic overrun_clear,
    input wire logic tx_wr,
    input wire spcs_pkg::spcs_byte_t tx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    output spcs_pkg::spcs_byte_t rx_data,
    output spcs_pkg::spcs_mode_t select_line_mode_field,
    output logic port_enable_bit,
    output logic tx_buffer_empty_flag,
    output logic rx_overrun_flag,
    output logic irq_req,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    input wire logic data_in,
    output logic data_out,
    output logic data_oe,
    input wire logic slave_select_line_in,
    output logic slave_select_line_out,
    output logic slave_select_line_oe
);
    import spcs_pkg::*;

    spcs_shift_if sh ();

    spcs_mode_t mode_ff, nxt_mode;
    logic en_ff, nxt_en;
    logic master_ff, nxt_master;
    spcs_byte_t hold_ff, nxt_hold;
    logic txe_ff, nxt_txe;
    logic ovr_ff, nxt_ovr;
    logic buf_ready;
    logic selected;
    logic overrun_event;

    // decoding used by both the pin logic and the engine
    function automatic logic drives_select(input spcs_mode_t m);
        return m[1];
    endfunction

    function automatic logic uses_select_input(input spcs_mode_t m);
        return (m == `SPCS_MODE_4WIRE_IN);
    endfunction

    // control word: mode field and enable, written as one word
    always_comb begin
        nxt_mode = mode_ff;
        nxt_en = en_ff;
        nxt_master = master_ff;
        if (ctrl_wr) begin
            nxt_mode = ctrl_wdata[`SPCS_MODE_HI:`SPCS_MODE_LO]; // [R3]
            nxt_en = ctrl_wdata[`SPCS_EN_BIT]; // [R9]
            nxt_master = master_select;
        end
    end

    // control registers; mode resets to four wire with select as input
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mode_ff <= `SPCS_MODE_RESET; // [R5]
            en_ff <= `SPCS_EN_RESET;
            master_ff <= `SPCS_MASTER_RESET;
        end else begin
            mode_ff <= nxt_mode;
            en_ff <= nxt_en;
            master_ff <= nxt_master;
        end
    end

    assign select_line_mode_field = mode_ff;
    assign port_enable_bit = en_ff;

    // select line routing per mode; three wire ignores the pin entirely
    always_comb begin
        slave_select_line_oe = 1'b0; // [R4]
        slave_select_line_out = 1'b1;
        selected = 1'b1;
        if (drives_select(mode_ff)) begin
            slave_select_line_oe = en_ff; // [R6]
            slave_select_line_out = mode_ff[0]; // [R6]
        end else if (uses_select_input(mode_ff)) begin
            selected = !slave_select_line_in; // [R5]
        end
    end

    // pin drivers: master owns the clock, a slave talks only when selected
    assign sck_oe = en_ff && master_ff;
    assign data_oe = en_ff && (master_ff || selected);

    // transmit holding register: a fresh write beats the move out
    assign sh.load = en_ff && !txe_ff && !sh.busy; // [R9]
    assign sh.load_data = hold_ff;

    always_comb begin
        nxt_hold = hold_ff;
        nxt_txe = txe_ff;
        if (tx_wr) begin
            nxt_hold = tx_data;
            nxt_txe = 1'b0; // [R7]
        end else if (sh.load) begin
            nxt_txe = 1'b1; // [R8]
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hold_ff <= `SPCS_BYTE_RESET;
            txe_ff <= `SPCS_TXE_RESET;
        end else begin
            hold_ff <= nxt_hold;
            txe_ff <= nxt_txe;
        end
    end

    assign tx_buffer_empty_flag = txe_ff;

    // overrun: a byte lands while unread data fills the buffer; that byte is lost
    assign overrun_event = sh.done && !buf_ready; // [R1]

    always_comb begin
        nxt_ovr = ovr_ff;
        if (overrun_event) begin
            nxt_ovr = 1'b1; // [R1]
        end else if (overrun_clear) begin
            nxt_ovr = 1'b0; // [R2]
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ovr_ff <= `SPCS_OVR_RESET;
        end else begin
            ovr_ff <= nxt_ovr;
        end
    end

    assign rx_overrun_flag = ovr_ff;
    assign irq_req = ovr_ff; // [R10]

    // engine and receive buffer
    spcs_shifter u_shifter (
        .clock(clock),
        .rst(rst),
        .sh(sh.engine),
        .master(master_ff),
        .enable(en_ff),
        .active(selected),
        .sck_in(sck_in),
        .data_in(data_in),
        .sck_out(sck_out),
        .data_out(data_out)
    );

    spcs_rx_buf u_rx_buf (
        .clock(clock),
        .rst(rst),
        .in_valid(sh.done),
        .in_ready(buf_ready),
        .in_data(sh.rx_data),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_data(rx_data)
    );

    // checks on the control and status behaviour
    a_ovr_set_event: assert property (@(posedge clock) disable iff (rst) // [R1]
        sh.done && !buf_ready |=> rx_overrun_flag)
        else $error("overrun not flagged");
    a_ovr_sticky: assert property (@(posedge clock) disable iff (rst) // [R2]
        rx_overrun_flag && !overrun_clear |=> rx_overrun_flag)
        else $error("overrun cleared without software");
    a_mode_field_load: assert property (@(posedge clock) disable iff (rst) // [R3]
        ctrl_wr |=> select_line_mode_field == $past(ctrl_wdata[3:2]))
        else $error("mode field not taken from bits 3:2");
    a_mode00_no_pin: assert property (@(posedge clock) disable iff (rst) // [R4]
        select_line_mode_field == 2'h0 |-> !slave_select_line_oe && selected)
        else $error("select line used in three wire mode");
    a_mode01_input: assert property (@(posedge clock) disable iff (rst) // [R5]
        select_line_mode_field == 2'h1 |-> !slave_select_line_oe
            && (selected == !slave_select_line_in))
        else $error("select line not an input");
    a_single_master_drive: assert property (@(posedge clock) disable iff (rst) // [R6]
        select_line_mode_field[1] && port_enable_bit |-> slave_select_line_oe
            && slave_select_line_out == select_line_mode_field[0])
        else $error("select line not driven from mode low bit");
    a_tx_write_clear: assert property (@(posedge clock) disable iff (rst) // [R7]
        tx_wr |=> !tx_buffer_empty_flag)
        else $error("empty flag still set after write");
    a_tx_move_set: assert property (@(posedge clock) disable iff (rst) // [R8]
        sh.load && !tx_wr |=> tx_buffer_empty_flag
            ##1 (sh.busy || !port_enable_bit || !master_ff))
        else $error("empty flag not set on move");
    a_disabled_quiet: assert property (@(posedge clock) disable iff (rst) // [R9]
        !port_enable_bit [*2] |-> !sh.done && !sh.load && !sck_oe)
        else $error("disabled port still active");
    a_irq_on_overrun: assert property (@(posedge clock) disable iff (rst) // [R10]
        $rose(rx_overrun_flag) |-> irq_req)
        else $error("no interrupt request on overrun");
endmodule // spcs_top

// ===== dv/spcs_far_slave.sv
// behavioural far-side serial slave answering this port in its master role
module spcs_far_slave (
    input wire logic sck,
    input wire logic sel_n,
    input wire logic mosi,
    input wire spcs_pkg::spcs_byte_t reply,
    output logic miso,
    output spcs_pkg::spcs_byte_t got
);
    timeunit 1ns;
    timeprecision 1ns;
    import spcs_pkg::*;

    spcs_byte_t sh;
    int cnt;

    initial begin
        sh = 8'h00;
        cnt = 0;
        got = 8'h00;
        miso = 1'b0;
    end

    // a fresh byte is loaded when selected
    always @(negedge sel_n) begin
        sh = reply;
        cnt = 0;
    end

    // sample on the rising serial edge, msb first
    always @(posedge sck) begin
        if (!sel_n) begin
            got = {got[6:0], mosi};
            cnt = cnt + 1;
        end
    end

    // shift on the falling edge; the eighth fall loads the next reply
    always @(negedge sck) begin
        if (!sel_n) begin
            if (cnt == 8) begin
                sh = reply;
                cnt = 0;
            end else begin
                sh = {sh[6:0], 1'b0};
            end
        end
    end

    // released line toggles so a stale value is never sampled by luck
    always @(sel_n or sh) begin
        if (!sel_n) begin
            miso = sh[7];
        end else begin
            miso = ~miso;
        end
    end
endmodule // spcs_far_slave

// ===== dv/spcs_top_bench.sv
// self-checking bench for the serial port control and status block
module spcs_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import spcs_pkg::*;

    logic clock = 1'b0;
    logic rst = 1'b1;
    logic ctrl_wr = 1'b0;
    logic [3:0] ctrl_wdata = 4'h0;
    logic master_select = 1'b0;
    logic overrun_clear = 1'b0;
    logic tx_wr = 1'b0;
    spcs_byte_t tx_data = 8'h00;
    logic rx_ready = 1'b0;
    logic rx_valid, port_enable_bit, tx_buffer_empty_flag, rx_overrun_flag, irq_req;
    spcs_byte_t rx_data, reply, got;
    spcs_mode_t select_line_mode_field;
    logic sck_out, sck_oe, data_out, data_oe, ss_out, ss_oe, miso;
    logic sck_pin, sel_pin, din_pin;
    logic fm_sck = 1'b0;
    logic fm_data = 1'b0;
    logic fm_sel = 1'b1;
    spcs_byte_t fm_got = 8'h00;
    int bad_count = 0;
    int comparisons = 0;
    int i;

    // far master owns clock and data whenever sck_oe is low, and select whenever ss_oe is low
    assign sck_pin = sck_oe ? sck_out : fm_sck;
    assign sel_pin = ss_oe ? ss_out : fm_sel;
    assign din_pin = sck_oe ? miso : fm_data;

    always #25 clock = ~clock;

    spcs_top spcs_top_inst (.clock(clock), .rst(rst), .ctrl_wr(ctrl_wr),
        .ctrl_wdata(ctrl_wdata), .master_select(master_select),
        .overrun_clear(overrun_clear), .tx_wr(tx_wr), .tx_data(tx_data),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
        .select_line_mode_field(select_line_mode_field),
        .port_enable_bit(port_enable_bit), .tx_buffer_empty_flag(tx_buffer_empty_flag),
        .rx_overrun_flag(rx_overrun_flag), .irq_req(irq_req), .sck_in(sck_pin),
        .sck_out(sck_out), .sck_oe(sck_oe), .data_in(din_pin), .data_out(data_out),
        .data_oe(data_oe), .slave_select_line_in(sel_pin),
        .slave_select_line_out(ss_out), .slave_select_line_oe(ss_oe));

    spcs_far_slave spcs_far_slave_inst (.sck(sck_pin), .sel_n(sel_pin),
        .mosi(data_oe ? data_out : 1'b0), .reply(reply), .miso(miso), .got(got));

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // one-cycle control write; the leading edge keeps two calls from retoggling the strobe
    task automatic ctrl_write(input logic [1:0] mode, input logic en, input logic mst);
        @(negedge clock);
        ctrl_wdata = {mode, 1'b0, en};
        master_select = mst;
        ctrl_wr = 1'b1;
        @(negedge clock);
        ctrl_wr = 1'b0;
    endtask

    task automatic tx_write(input spcs_byte_t b);
        @(negedge clock);
        tx_data = b;
        tx_wr = 1'b1;
        @(negedge clock);
        tx_wr = 1'b0;
        check("empty after write", {7'h0, tx_buffer_empty_flag}, 8'h00);
        for (i = 0; i < 200 && tx_buffer_empty_flag !== 1'b1; i++) @(negedge clock);
        check("empty after move", {7'h0, tx_buffer_empty_flag}, 8'h01);
    endtask

    task automatic rx_pop(input spcs_byte_t exp);
        @(negedge clock);
        for (i = 0; i < 200 && rx_valid !== 1'b1; i++) @(negedge clock);
        check("rx_data", rx_data, exp);
        rx_ready = 1'b1;
        @(negedge clock);
        rx_ready = 1'b0;
    endtask

    // far master for the slave role: drive on the fall, sample on the rise, msb first
    task automatic far_master_byte(input spcs_byte_t mo);
        for (int b = 7; b >= 0; b--) begin
            fm_data = mo[b];
            repeat (4) @(negedge clock);
            fm_sck = 1'b1;
            fm_got = {fm_got[6:0], data_out};
            repeat (4) @(negedge clock);
            fm_sck = 1'b0;
        end
    endtask

    // watchdog: the whole sequence needs well under 2000 cycles
    initial begin
        #(5000 * 50);
        bad_count++;
        $display("Error watchdog expected done seen hang");
        stop_test();
    end

    initial begin
        reply = 8'h3C;
        repeat (3) @(negedge clock);
        rst = 1'b0;
        @(negedge clock);
        check("mode reset", {6'h0, select_line_mode_field}, 8'h01);
        check("enable reset", {7'h0, port_enable_bit}, 8'h00);
        check("empty reset", {7'h0, tx_buffer_empty_flag}, 8'h01);
        check("overrun reset", {7'h0, rx_overrun_flag}, 8'h00);
        check("select oe reset", {7'h0, ss_oe}, 8'h00);
        $display("test reset done");

        // every select mode, enabled master
        for (int m = 0; m < 4; m++) begin
            ctrl_write(m[1:0], 1'b1, 1'b1);
            check("mode field", {6'h0, select_line_mode_field}, m[7:0]);
            check("enable", {7'h0, port_enable_bit}, 8'h01);
            check("select oe", {7'h0, ss_oe}, {7'h0, m[1]});
            if (m[1]) check("select level", {7'h0, ss_out}, {7'h0, m[0]});
        end
        $display("test modes done");

        // single byte: reply loaded at select fall
        ctrl_write(2'h2, 1'b1, 1'b1);
        tx_write(8'hA5);
        rx_pop(8'h3C);
        check("far side got", got, 8'hA5);
        $display("test single byte done");

        // three bytes unread: third is dropped and overrun sticks
        reply = 8'h11;
        ctrl_write(2'h3, 1'b1, 1'b1);
        ctrl_write(2'h2, 1'b1, 1'b1);
        tx_write(8'h81);
        reply = 8'h22;
        tx_write(8'h82);
        reply = 8'h33;
        tx_write(8'h83);
        for (i = 0; i < 200 && rx_overrun_flag !== 1'b1; i++) @(negedge clock);
        check("overrun set", {7'h0, rx_overrun_flag}, 8'h01);
        check("irq", {7'h0, irq_req}, 8'h01);
        repeat (40) @(negedge clock);
        rx_pop(8'h11);
        rx_pop(8'h22);
        check("rx empty", {7'h0, rx_valid}, 8'h00);
        check("overrun held", {7'h0, rx_overrun_flag}, 8'h01);
        overrun_clear = 1'b1;
        @(negedge clock);
        overrun_clear = 1'b0;
        check("overrun cleared", {7'h0, rx_overrun_flag}, 8'h00);
        check("irq cleared", {7'h0, irq_req}, 8'h00);
        $display("test overrun done");

        // slave role with select as input: far master swaps one byte each way
        ctrl_write(2'h1, 1'b1, 1'b0);
        check("slave data oe idle", {7'h0, data_oe}, 8'h00);
        tx_write(8'h5A);
        fm_sel = 1'b0;
        @(negedge clock);
        check("slave data oe", {7'h0, data_oe}, 8'h01);
        far_master_byte(8'hC3);
        check("far master got", fm_got, 8'h5A);
        rx_pop(8'hC3);
        fm_sel = 1'b1;
        $display("test slave done");

        // disabling releases every driven pin
        ctrl_write(2'h2, 1'b0, 1'b1);
        check("enable off", {7'h0, port_enable_bit}, 8'h00);
        check("clock oe off", {7'h0, sck_oe}, 8'h00);
        check("select oe off", {7'h0, ss_oe}, 8'h00);
        check("data oe off", {7'h0, data_oe}, 8'h00);
        $display("test disable done");
        stop_test();
    end
endmodule // spcs_top_bench
